// *** src/sram_port_pkg.sv ***
// shared constants and types for the two-word burst memory port
package sram_port_pkg;
    // ***********************************
    // geometry
    // ***********************************
    localparam int WORD_W_DEF    = 18;
    localparam int ADDR_W_DEF    = 10;
    localparam int BURST_WORDS   = 2;
    localparam int LANE_GROUP    = 9;
    localparam int NIBBLE_W      = 4;
    localparam int WIDTH_NIBBLE  = 8;
    // ***********************************
    // timing
    // ***********************************
    localparam int READ_LAT      = 2;
    localparam int BUF_DEPTH     = 2;
    typedef enum logic {DIR_WRITE, DIR_READ} dir_t;

    // number of write selects for a given bus width
    function automatic int sel_count(input int w);
        if (w == WIDTH_NIBBLE) return w / NIBBLE_W;
        return (w + LANE_GROUP - 1) / LANE_GROUP;
    endfunction
    // lane group width for a given bus width
    function automatic int sel_span(input int w);
        if (w == WIDTH_NIBBLE) return NIBBLE_W;
        return LANE_GROUP;
    endfunction
endpackage

// *** src/sram_port_if.sv ***
// link between memory controller and two-word burst memory
`timescale 1ns/1ps
interface sram_port_if #(parameter int WORD_W = 18, parameter int ADDR_W = 10);
    localparam int SEL_W = sram_port_pkg::sel_count(WORD_W);
    logic              cycle_start_n;
    logic              rd_wr;
    logic [ADDR_W-1:0] addr;
    logic [SEL_W-1:0]  byte_write_sel_n;
    logic [WORD_W-1:0] dq_from_ctrl;
    logic              dq_oe_ctrl;
    logic [WORD_W-1:0] dq_from_mem;
    logic              dq_oe_mem;
    logic              out_clk;
    logic              out_clk_n;
    logic [1:0]        echo_strobe_pair;
    logic              half;
    modport ctrl (output cycle_start_n, rd_wr, addr, byte_write_sel_n, dq_from_ctrl,
                  dq_oe_ctrl, out_clk, out_clk_n, half,
                  input dq_from_mem, dq_oe_mem, echo_strobe_pair);
    modport mem  (input cycle_start_n, rd_wr, addr, byte_write_sel_n, dq_from_ctrl,
                  dq_oe_ctrl, out_clk, out_clk_n, half,
                  output dq_from_mem, dq_oe_mem, echo_strobe_pair);
endinterface

// *** src/burst_mem.sv ***
// memory end: burst decode, masked writes, read launch, echo strobes
`timescale 1ns/1ps
// Notes on behaviour
// - address incl. low bit taken at rising edge
// - each transaction moves exactly two words
// - low address bit picks first word
// - address ignored while not loaded
// - write words taken on two successive rising edges
// - only echo strobe timing depends on output clocks
// - bus width 8, 9, 18 or 36
// - controller pulls load strobe low to start
// - direction high reads, low writes
// - only selected bytes are written
// - selects sampled separately for each word
// - eight-bit width uses nibble selects
// - second word has low bit inverted
// - first read word on the rising edge after load, second on the next
// - echo strobes run continuously
module burst_mem
    import sram_port_pkg::*;
#(
    parameter int WORD_W = WORD_W_DEF,
    parameter int ADDR_W = ADDR_W_DEF
)(
    input  wire logic  mclk,
    input  wire logic  nrst,
    sram_port_if.mem   link,
    output logic       busy
);
    localparam int SEL_W = sel_count(WORD_W);
    localparam int SPAN  = sel_span(WORD_W);
    // ***********************************
    // storage
    // ***********************************
    // no reset on the array: contents survive like a real part
    logic [WORD_W-1:0] mem_array [2**ADDR_W];
    typedef enum logic [1:0] {IDLE, WR2, RD1, RD2} st_t;
    st_t               st_reg, st_next;
    logic [ADDR_W-1:0] base_reg, base_next;
    logic [WORD_W-1:0] q_reg, q_next;
    logic              oe_reg, oe_next;
    logic [1:0]        echo_reg, echo_next;
    logic              use_k;

    // lane mask from active-low selects
    function automatic logic [WORD_W-1:0] lane_mask(input logic [SEL_W-1:0] sel_n);
        logic [WORD_W-1:0] m;
        m = '0;
        for (int i = 0; i < WORD_W; i++) m[i] = ~sel_n[i / SPAN];
        return m;
    endfunction
    function automatic logic [ADDR_W-1:0] partner(input logic [ADDR_W-1:0] a);
        return {a[ADDR_W-1:1], ~a[0]};
    endfunction

    // tied-high output clocks fall back to input clock timing
    assign use_k = link.out_clk & link.out_clk_n;
    // ***********************************
    // sequencing
    // ***********************************
    always_comb begin
        st_next   = st_reg;
        base_next = base_reg;
        q_next    = q_reg;
        oe_next   = 1'b0;
        echo_next = {~echo_reg[1], echo_reg[1]};
        unique case (st_reg)
            IDLE: begin
            end
            WR2: begin
                st_next = IDLE;
            end
            RD1: begin
                q_next  = mem_array[base_reg];
                oe_next = 1'b1;
                st_next = RD2;
            end
            RD2: begin
                q_next  = mem_array[partner(base_reg)];
                oe_next = 1'b1;
                st_next = IDLE;
            end
        endcase
        if (!link.cycle_start_n && (st_reg == IDLE || st_reg == WR2 || st_reg == RD2)) begin
            base_next = link.addr;
            st_next   = (link.rd_wr == DIR_READ) ? RD1 : WR2;
        end
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_reg   <= IDLE;
            base_reg <= '0;
            q_reg    <= '0;
            oe_reg   <= 1'b0;
            echo_reg <= 2'h1;
        end else begin
            st_reg   <= st_next;
            base_reg <= base_next;
            q_reg    <= q_next;
            oe_reg   <= oe_next;
            echo_reg <= echo_next;
        end
    end
    // ***********************************
    // write path
    // ***********************************
    // first word taken in the load cycle phase, second in the next
    always_ff @(posedge mclk) begin
        if (!link.cycle_start_n && link.rd_wr == DIR_WRITE && link.half == 1'b0)
            mem_array[link.addr] <= (mem_array[link.addr] & ~lane_mask(link.byte_write_sel_n))
                | (link.dq_from_ctrl & lane_mask(link.byte_write_sel_n));
        else if (st_reg == WR2)
            mem_array[partner(base_reg)] <= (mem_array[partner(base_reg)]
                & ~lane_mask(link.byte_write_sel_n))
                | (link.dq_from_ctrl & lane_mask(link.byte_write_sel_n));
    end
    assign link.dq_from_mem      = q_reg;
    assign link.dq_oe_mem        = oe_reg;
    assign link.echo_strobe_pair = use_k ? {~echo_reg[1], echo_reg[1]} : echo_reg;
    assign busy                  = (st_reg != IDLE);
endmodule // burst_mem

// *** src/burst_ctrl.sv ***
// controller end: issues two-word bursts, buffers read words
`timescale 1ns/1ps
module burst_ctrl
    import sram_port_pkg::*;
#(
    parameter int WORD_W = WORD_W_DEF,
    parameter int ADDR_W = ADDR_W_DEF
)(
    input  wire logic                            mclk,
    input  wire logic                            nrst,
    sram_port_if.ctrl                            link,
    input  wire logic                            req_valid,
    output logic                                 req_ready,
    input  wire logic                            req_read,
    input  wire logic [ADDR_W-1:0]               req_addr,
    input  wire logic [2*WORD_W-1:0]             req_wdata,
    input  wire logic [2*sel_count(WORD_W)-1:0]  req_sel_n,
    output logic                                 rd_valid,
    input  wire logic                            rd_ready,
    output logic [WORD_W-1:0]                    rd_data
);
    localparam int SEL_W = sel_count(WORD_W);
    typedef enum logic [1:0] {C_IDLE, C_W2, C_R1, C_R2} cst_t;
    cst_t              cst_reg, cst_next;
    logic [WORD_W-1:0] w2_reg, w2_next;
    logic [SEL_W-1:0]  s2_reg, s2_next;
    logic [WORD_W-1:0] buf_reg [BUF_DEPTH];
    logic [WORD_W-1:0] buf_next [BUF_DEPTH];
    logic [1:0]        cnt_reg, cnt_next;
    logic              start;
    // ***********************************
    // issue
    // ***********************************
    // a read is only issued when both buffer slots are free, so no word is lost
    // both write words use mclk edges, so a new load waits out the second word;
    // a write also waits while the memory still drives read words
    assign req_ready = (cst_reg == C_IDLE)
        && (req_read ? (cnt_reg == 2'h0) : !link.dq_oe_mem);
    assign start     = req_valid && req_ready;
    always_comb begin
        cst_next = C_IDLE;
        w2_next  = w2_reg;
        s2_next  = s2_reg;
        if (cst_reg == C_R1)
            cst_next = C_R2;
        else if (cst_reg == C_R2)
            cst_next = C_IDLE;
        if (start) begin
            cst_next = req_read ? C_R1 : C_W2;
            w2_next  = req_wdata[2*WORD_W-1:WORD_W];
            s2_next  = req_sel_n[2*SEL_W-1:SEL_W];
        end
    end
    assign link.cycle_start_n    = ~start;
    assign link.rd_wr            = req_read;
    assign link.addr             = req_addr;
    assign link.half             = (cst_reg == C_W2);
    assign link.dq_oe_ctrl       = (start && !req_read) || cst_reg == C_W2;
    assign link.dq_from_ctrl     = (cst_reg == C_W2) ? w2_reg : req_wdata[WORD_W-1:0];
    assign link.byte_write_sel_n = (cst_reg == C_W2) ? s2_reg : req_sel_n[SEL_W-1:0];
    assign link.out_clk          = 1'b1;
    assign link.out_clk_n        = 1'b1;
    // ***********************************
    // read buffer
    // ***********************************
    always_comb begin
        buf_next = buf_reg;
        cnt_next = cnt_reg;
        if (rd_valid && rd_ready) begin
            buf_next[0] = buf_reg[1];
            cnt_next    = cnt_next - 2'h1;
        end
        if (link.dq_oe_mem) begin
            buf_next[cnt_next[0]] = link.dq_from_mem;
            cnt_next              = cnt_next + 2'h1;
        end
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cst_reg <= C_IDLE;
            w2_reg  <= '0;
            s2_reg  <= '0;
            cnt_reg <= 2'h0;
            for (int i = 0; i < BUF_DEPTH; i++) buf_reg[i] <= '0;
        end else begin
            cst_reg <= cst_next;
            w2_reg  <= w2_next;
            s2_reg  <= s2_next;
            cnt_reg <= cnt_next;
            buf_reg <= buf_next;
        end
    end
    assign rd_valid = (cnt_reg != 2'h0);
    assign rd_data  = buf_reg[0];
endmodule // burst_ctrl

// *** verif/sram_port_checker.sv ***
// link checker for the controller-to-memory burst port
`timescale 1ns/1ps
module sram_port_checker
    import sram_port_pkg::*;
(
    input wire logic       mclk,
    input wire logic       nrst,
    input wire logic       cycle_start_n,
    input wire logic       rd_wr,
    input wire logic       dq_oe_ctrl,
    input wire logic       dq_oe_mem,
    input wire logic       out_clk,
    input wire logic       out_clk_n,
    input wire logic [1:0] echo_strobe_pair,
    input wire logic       half
);
    // ****************************
    // link properties
    // ****************************
    logic rd_ld;
    logic wr_ld;
    assign rd_ld = !cycle_start_n && rd_wr;
    assign wr_ld = !cycle_start_n && !rd_wr;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence rd_load; rd_ld; endsequence
    sequence wr_load; wr_ld; endsequence
    sequence two_mem_words; ##2 dq_oe_mem [*2]; endsequence
    AST_READ_TWO_WORDS: assert property (rd_load |-> two_mem_words)
        else $error("read burst did not drive two words");
    AST_MEM_OE_CAUSE: assert property ($rose(dq_oe_mem) |-> $past(rd_ld, 2))
        else $error("memory drove bus without a read load");
    AST_WRITE_WORDS: assert property (wr_load |-> dq_oe_ctrl ##1 (dq_oe_ctrl && half))
        else $error("write burst words not on two edges");
    AST_HALF_CAUSE: assert property (half |-> $past(wr_ld))
        else $error("second word phase without write load");
    AST_NO_CLASH: assert property (!(dq_oe_ctrl && dq_oe_mem))
        else $error("both ends drive the data bus");
    AST_OUT_CLK_TIED: assert property (out_clk && out_clk_n)
        else $error("output clocks not held high");
    AST_ECHO_RUNS: assert property (echo_strobe_pair == 2'h1 |-> ##[1:2] echo_strobe_pair == 2'h2)
        else $error("echo strobes stopped");
    AST_ECHO_PAIR: assert property (echo_strobe_pair[0] != echo_strobe_pair[1])
        else $error("echo strobes not complementary");
    AST_READ_ONE_LOAD: assert property (rd_load |=> cycle_start_n)
        else $error("load during second read cycle");
endmodule // sram_port_checker

// *** verif/tb.sv ***
// self-checking bench for the controller and memory pair
`timescale 1ns/1ps
module tb;
    import sram_port_pkg::*;
    localparam int W = 18;
    localparam int A = 10;
    localparam int S = sel_count(W);
    logic           mclk, nrst, req_valid, req_ready, req_read, rd_valid, rd_ready, busy;
    logic [A-1:0]   req_addr;
    logic [2*W-1:0] req_wdata;
    logic [2*S-1:0] req_sel_n;
    logic [W-1:0]   rd_data;
    int             n_errors = 0;
    int             check_count = 0;
    int             cyc = 0;
    sram_port_if #(.WORD_W(W), .ADDR_W(A)) link ();
    burst_ctrl #(.WORD_W(W), .ADDR_W(A)) u_burst_ctrl (.mclk(mclk), .nrst(nrst),
        .link(link.ctrl), .req_valid(req_valid), .req_ready(req_ready), .req_read(req_read),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_sel_n(req_sel_n),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
    burst_mem #(.WORD_W(W), .ADDR_W(A)) u_burst_mem (.mclk(mclk), .nrst(nrst),
        .link(link.mem), .busy(busy));
    sram_port_checker u_sram_port_checker (.mclk(mclk), .nrst(nrst),
        .cycle_start_n(link.cycle_start_n), .rd_wr(link.rd_wr), .dq_oe_ctrl(link.dq_oe_ctrl),
        .dq_oe_mem(link.dq_oe_mem), .out_clk(link.out_clk), .out_clk_n(link.out_clk_n),
        .echo_strobe_pair(link.echo_strobe_pair), .half(link.half));
    // ****************************
    // tasks
    // ****************************
    task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // issue one burst; waits out refusals at falling edges
    task automatic req(input logic rd, input logic [A-1:0] ad, input logic [2*W-1:0] wd,
                       input logic [2*S-1:0] sn);
        int i;
        req_valid = 1'b1;
        req_read = rd;
        req_addr = ad;
        req_wdata = wd;
        req_sel_n = sn;
        #1;
        for (i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge mclk) #1;
        if (i == 50) n_errors++;
        @(negedge mclk);
        req_valid = 1'b0;
        @(negedge mclk);
    endtask
    task automatic get(input logic [W-1:0] exp);
        int i;
        for (i = 0; i < 20 && rd_valid !== 1'b1; i++) @(negedge mclk);
        chk(rd_data, exp);
        @(negedge mclk);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ****************************
    // sequence
    // ****************************
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // generous ceiling: the tests take well under 200 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            wrap_up();
        end
    end
    initial begin
        nrst = 1'b0;
        req_valid = 1'b0;
        req_read = 1'b0;
        req_addr = '0;
        req_wdata = '0;
        req_sel_n = '1;
        rd_ready = 1'b1;
        repeat (3) @(negedge mclk);
        nrst = 1'b1;
        @(negedge mclk);
        req(1'b0, 10'h004, {18'h2BEEF, 18'h1CAFE}, 4'h0);
        req(1'b1, 10'h004, '0, 4'hF);
        get(18'h1CAFE);
        get(18'h2BEEF);
        req(1'b1, 10'h005, '0, 4'hF);
        get(18'h2BEEF);
        get(18'h1CAFE);
        $display("test burst_order done");
        req(1'b0, 10'h010, {18'h3FFFF, 18'h3FFFF}, 4'h0);
        req(1'b0, 10'h010, '0, 4'h6);
        req(1'b1, 10'h010, '0, 4'hF);
        get(18'h3FE00);
        get(18'h001FF);
        $display("test byte_mask done");
        rd_ready = 1'b0;
        req(1'b1, 10'h011, '0, 4'hF);
        repeat (6) @(negedge mclk);
        req_read = 1'b1;
        #1;
        chk({17'h0, rd_valid}, 18'h00001);
        chk({17'h0, req_ready}, 18'h00000);
        chk(rd_data, 18'h001FF);
        @(negedge mclk);
        rd_ready = 1'b1;
        get(18'h001FF);
        get(18'h3FE00);
        chk({17'h0, busy}, 18'h00000);
        $display("test stall done");
        wrap_up();
    end
endmodule // tb
